// ===== aphp_pkg.sv
// package for the parallel host port: constants and carrier types
package aphp_pkg;
  localparam int NUM_CH = 8;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 7;
  // internal register addresses
  localparam logic [6:0] ADDR_RESULT_MODE = 7'h00;
  localparam logic [6:0] ADDR_CONFIG = 7'h02;
  localparam logic [6:0] ADDR_DIAG_CFG = 7'h21;
  // field positions
  localparam int CFG_STATUS_BIT = 6;
  localparam int DIAG_CRC_BIT = 2;
  localparam int FRAME_RW_BIT = 15;
  // reset values and checksum polynomial
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] DIAG_CFG_RST = 8'h00;
  localparam logic [15:0] CRC_SEED = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  // wishbone register offsets (byte addresses)
  localparam logic [7:0] WB_CTRL_OFS = 8'h00;
  localparam logic [7:0] WB_STAT_OFS = 8'h04;
  localparam logic [7:0] WB_CH_OFS = 8'h20;
  localparam logic [7:0] WB_FLAG_OFS = 8'h40;

  typedef enum logic [2:0] {
    ST_RESULT = 3'b001,
    ST_STATUS = 3'b010,
    ST_CRC = 3'b100
  } aphp_seq_t;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [15:0] data;
  } aphp_pins_in_t;

  typedef struct packed {
    logic [15:0] data;
    logic data_oe_n;
    logic first;
    logic first_oe_n;
  } aphp_pins_out_t;
endpackage

// ===== aphp_port.sv
// parallel host port of an eight-channel converter, with wishbone side access
// Function
// R1: low select chooses parallel port
// R2: hardware mode reads results only
// R3: software mode needs all oversample pins high
// R4: select rise floats bus, fall drives
// R5: read fall steps channels one to eight
// R6: host may tie select low
// R7: host reads new data after busy
// R8: shared select/read fall drives and steps
// R9: first flag driven under select, high channel one
// R10: results load at busy falling edge
// R11: host avoids reading at busy fall
// R12: checksum appended when enabled
// R13: checksum covers every driven word
// R14: status enable gives two frames per channel
// R15: status header upper byte, zeros below
// R16: status header layout with channel tag
// R17: register mode drives only on read
// R18: read command sets bit fifteen
// R19: address captured at write rise
// R20: next read returns address and contents
// R21: address zero write leaves register mode
// R22: register write is a single frame
// R23: host reads a register before writes
// R24: host releases bus when write high
// R25: sequence restarts after busy fall
//
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module aphp_port (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // mode straps
  input wire logic interface_select_i,
  input wire logic [2:0] os_select_i,
  // converter side
  input wire logic busy_i,
  input wire logic [aphp_pkg::NUM_CH*16-1:0] conv_data_i,
  input wire logic [aphp_pkg::NUM_CH*5-1:0] diag_flags_i,
  // parallel pins
  input wire aphp_pkg::aphp_pins_in_t pins_i,
  output aphp_pkg::aphp_pins_out_t pins_o,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import aphp_pkg::*;

  // the channel tag and the header layout are fixed at eight channels
  if (NUM_CH != 8) begin : g_ch_check
    $error("eight channels only");
  end

  ////////////////////////////////////////////////////////////////////////
  // edge detection of pin strobes, pins sampled as synchronous
  logic cs_q, rd_q, wr_q, busy_q;
  logic cs_fall, cs_rise, rd_fall, wr_rise, busy_fall;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_q <= 1'b1;
      rd_q <= 1'b1;
      wr_q <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      cs_q <= pins_i.cs_n;
      rd_q <= pins_i.rd_n;
      wr_q <= pins_i.wr_n;
      busy_q <= busy_i;
    end
  end
  assign cs_fall = cs_q & ~pins_i.cs_n;
  assign cs_rise = ~cs_q & pins_i.cs_n;
  // a shared select/read line falls both at once and still steps
  assign rd_fall = rd_q & ~pins_i.rd_n & ~pins_i.cs_n; // R8
  assign wr_rise = ~wr_q & pins_i.wr_n & ~pins_i.cs_n;
  assign busy_fall = busy_q & ~busy_i; // R10

  logic par_mode, sw_mode;
  assign par_mode = ~interface_select_i; // R1
  assign sw_mode = &os_select_i; // R3

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [NUM_CH*16-1:0] res_q, res_d;
  logic [NUM_CH*5-1:0] flg_q, flg_d;
  logic [7:0] config_q, config_d, diag_q, diag_d;
  logic reg_mode_q, reg_mode_d;
  logic [6:0] reg_addr_q, reg_addr_d;
  logic [2:0] ch_q, ch_d;
  aphp_seq_t seq_q, seq_d;
  logic done_q, done_d;
  logic [15:0] crc_q, crc_d;
  logic [15:0] dout_q, dout_d;
  logic oe_n_q, oe_n_d, first_q, first_d, fo_n_q, fo_n_d;
  logic reset_seen_q, reset_seen_d;
  logic [15:0] rd_cnt_q, rd_cnt_d;
  logic [31:0] wb_dat_d;
  logic wb_ack_d;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] w);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      r = r[15] ^ w[i] ? {r[14:0], 1'b0} ^ CRC_POLY : {r[14:0], 1'b0};
    end
    return r;
  endfunction

  function automatic logic [7:0] reg_read(input logic [6:0] a, input logic [7:0] cfg,
                                          input logic [7:0] dg);
    if (a == ADDR_CONFIG) reg_read = cfg;
    else if (a == ADDR_DIAG_CFG) reg_read = dg;
    else reg_read = 8'h00;
  endfunction

  logic [15:0] word_sel;
  logic [7:0] hdr;
  always_comb begin
    hdr = {reset_seen_q, flg_q[ch_q*5+4], flg_q[ch_q*5+3], flg_q[ch_q*5+2],
           flg_q[ch_q*5+1], ch_q}; // R16
    if (reg_mode_q) begin
      word_sel = {1'b0, reg_addr_q, reg_read(reg_addr_q, config_q, diag_q)}; // R20
    end else begin
      case (seq_q)
        ST_STATUS: word_sel = {hdr, 8'h00}; // R15
        ST_CRC: word_sel = crc_q; // R12
        default: word_sel = res_q[ch_q*16 +: 16]; // R5
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    res_d = res_q;
    flg_d = flg_q;
    config_d = config_q;
    diag_d = diag_q;
    reg_mode_d = reg_mode_q;
    reg_addr_d = reg_addr_q;
    ch_d = ch_q;
    seq_d = seq_q;
    done_d = done_q;
    crc_d = crc_q;
    dout_d = dout_q;
    oe_n_d = oe_n_q;
    first_d = first_q;
    fo_n_d = fo_n_q;
    reset_seen_d = reset_seen_q;
    rd_cnt_d = rd_cnt_q;
    if (cs_rise || !par_mode) begin
      oe_n_d = 1'b1; // R4
      fo_n_d = 1'b1; // R9
    end else if (cs_fall) begin
      fo_n_d = 1'b0; // R9
      oe_n_d = reg_mode_q & pins_i.rd_n; // R4 R17
    end
    if (par_mode && !pins_i.cs_n && !pins_i.wr_n) oe_n_d = 1'b1; // R17
    if (par_mode && rd_fall) begin
      oe_n_d = 1'b0;
      dout_d = word_sel;
      rd_cnt_d = rd_cnt_q + 16'h0001;
      first_d = 1'b0; // R9
      if (!reg_mode_q && !done_q) begin
        crc_d = seq_q == ST_CRC ? crc_q : crc_step(crc_q, word_sel); // R13
        reset_seen_d = 1'b0;
        if (seq_q == ST_RESULT) first_d = (ch_q == 3'h0); // R9
        if (seq_q == ST_RESULT && sw_mode && config_q[CFG_STATUS_BIT]) begin
          seq_d = ST_STATUS; // R14
        end else if (seq_q == ST_CRC) begin
          done_d = 1'b1;
        end else if (ch_q == 3'h7) begin
          ch_d = 3'h0;
          if (sw_mode && diag_q[DIAG_CRC_BIT]) seq_d = ST_CRC; // R12
          else begin
            seq_d = ST_RESULT;
          end
        end else begin
          ch_d = ch_q + 3'h1; // R5
          seq_d = ST_RESULT;
        end
      end
    end
    if (par_mode && wr_rise && sw_mode) begin // R2
      if (pins_i.data[FRAME_RW_BIT]) begin
        reg_mode_d = 1'b1; // R18
        reg_addr_d = pins_i.data[14:8]; // R19
      end else if (pins_i.data[14:8] == ADDR_RESULT_MODE) begin
        reg_mode_d = 1'b0; // R21
      end else begin
        if (pins_i.data[14:8] == ADDR_CONFIG) config_d = pins_i.data[7:0];
        if (pins_i.data[14:8] == ADDR_DIAG_CFG) diag_d = pins_i.data[7:0];
      end
    end
    if (!sw_mode) reg_mode_d = 1'b0; // R2
    if (busy_fall) begin
      res_d = conv_data_i; // R10
      flg_d = diag_flags_i;
      ch_d = 3'h0; // R25
      seq_d = ST_RESULT;
      done_d = 1'b0;
      crc_d = CRC_SEED;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      res_q <= '0;
      flg_q <= '0;
      config_q <= CONFIG_RST;
      diag_q <= DIAG_CFG_RST;
      reg_mode_q <= 1'b0;
      reg_addr_q <= 7'h00;
      ch_q <= 3'h0;
      seq_q <= ST_RESULT;
      done_q <= 1'b0;
      crc_q <= CRC_SEED;
      dout_q <= 16'h0000;
      oe_n_q <= 1'b1;
      first_q <= 1'b0;
      fo_n_q <= 1'b1;
      reset_seen_q <= 1'b1;
      rd_cnt_q <= 16'h0000;
    end else begin
      res_q <= res_d;
      flg_q <= flg_d;
      config_q <= config_d;
      diag_q <= diag_d;
      reg_mode_q <= reg_mode_d;
      reg_addr_q <= reg_addr_d;
      ch_q <= ch_d;
      seq_q <= seq_d;
      done_q <= done_d;
      crc_q <= crc_d;
      dout_q <= dout_d;
      oe_n_q <= oe_n_d;
      first_q <= first_d;
      fo_n_q <= fo_n_d;
      reset_seen_q <= reset_seen_d;
      rd_cnt_q <= rd_cnt_d;
    end
  end

  // one driver for the whole carrier, members filled from their flops
  assign pins_o = '{data: dout_q, data_oe_n: oe_n_q, first: first_q, first_oe_n: fo_n_q};

  ////////////////////////////////////////////////////////////////////////
  // wishbone slave: single-cycle ack, one idle cycle forced between
  logic wb_hit;
  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  always_comb begin
    wb_ack_d = wb_hit;
    wb_dat_d = 32'h0000_0000;
    if (wb_hit && !wb_we_i) begin
      if (wb_adr_i == WB_CTRL_OFS) wb_dat_d = {16'h0000, diag_q, config_q};
      else if (wb_adr_i == WB_STAT_OFS) begin
        wb_dat_d = {rd_cnt_q, 3'h0, reg_mode_q, reg_addr_q, sw_mode, done_q, ch_q};
      end else if (wb_adr_i >= WB_CH_OFS && wb_adr_i < WB_CH_OFS + 8'h20) begin
        wb_dat_d = {16'h0000, res_q[wb_adr_i[4:2]*16 +: 16]};
      end else if (wb_adr_i >= WB_FLAG_OFS && wb_adr_i < WB_FLAG_OFS + 8'h20) begin
        wb_dat_d = {27'h0, flg_q[wb_adr_i[4:2]*5 +: 5]};
      end
    end
  end
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_ack_d;
      wb_dat_o <= wb_dat_d;
    end
  end
endmodule

// ===== aphp_port_sva.sv
// assertions on the parallel pins and the wishbone answer
`timescale 1ns/1ps
module aphp_port_sva (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // watched ports
  input wire logic interface_select_i,
  input wire aphp_pkg::aphp_pins_in_t pins_i,
  input wire aphp_pkg::aphp_pins_out_t pins_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  a_cs_float: assert property (pins_i.cs_n |=> pins_o.data_oe_n)
    else $error("bus driven while deselected");
  a_serial_float: assert property (interface_select_i |=> pins_o.data_oe_n)
    else $error("bus driven in serial selection");
  a_first_float: assert property (pins_i.cs_n |=> pins_o.first_oe_n)
    else $error("first flag driven while deselected");
  a_rd_drive: assert property ($fell(pins_i.rd_n) && !pins_i.cs_n
    && !interface_select_i |=> !pins_o.data_oe_n) else $error("read fall not driving");
  a_wr_listen: assert property (!pins_i.cs_n && !pins_i.wr_n |=> pins_o.data_oe_n)
    else $error("bus driven during write");
  a_first_on_read: assert property ($rose(pins_o.first)
    |-> !$past(pins_i.rd_n) && $past(pins_i.rd_n, 2)) else $error("first flag without read");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule

// ===== aphp_host.sv
// host model driving the parallel pins of the port
`timescale 1ns/1ps
module aphp_host (
  // clock
  input wire logic clk_i,
  // device pins
  input wire aphp_pkg::aphp_pins_out_t dev_i,
  output aphp_pkg::aphp_pins_in_t pins_o
);
  import aphp_pkg::*;
  initial pins_o = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, data: 16'h0000};
  // select and read fall together, a shared strobe
  task automatic rd(input int h, output logic [16:0] v);
    pins_o.cs_n <= 1'b0;
    pins_o.rd_n <= 1'b0;
    repeat (h) @(posedge clk_i);
    v = {dev_i.first, dev_i.data};
    pins_o.cs_n <= 1'b1;
    pins_o.rd_n <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic wr(input logic [15:0] d);
    pins_o.data <= d;
    pins_o.cs_n <= 1'b0;
    pins_o.wr_n <= 1'b0;
    repeat (3) @(posedge clk_i);
    // write strobe rises while select still stands low, so the edge is taken
    pins_o.wr_n <= 1'b1;
    @(posedge clk_i);
    pins_o.cs_n <= 1'b1;
    @(posedge clk_i);
    // released bus shows no stale word
    pins_o.data <= ~d;
    @(posedge clk_i);
  endtask
  // select held by the caller, the read strobe alone steps the bus
  task automatic rd_strobe(input int h, output logic [16:0] v);
    pins_o.rd_n <= 1'b0;
    repeat (h) @(posedge clk_i);
    v = {dev_i.first, dev_i.data};
    pins_o.rd_n <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic hold_sel(input logic n);
    pins_o.cs_n <= n;
    repeat (2) @(posedge clk_i);
  endtask
endmodule

// ===== aphp_port_tb.sv
// self-checking bench for the parallel host port
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module aphp_port_tb;
  import aphp_pkg::*;
  logic clk = 0, rst_n = 0, sel = 0, busy = 0, cyc = 0, stb = 0, we = 0, ack;
  logic [2:0] os = 3'b111;
  logic [127:0] conv = '0;
  logic [39:0] diag = '0;
  logic [7:0] adr = 8'h00;
  logic [31:0] rdat, w;
  logic [16:0] v;
  logic [15:0] crc;
  aphp_pins_in_t hp;
  aphp_pins_out_t dev;
  int num_errors = 0, comparisons = 0, cycles = 0;
  aphp_port dut (.sys_clk_i(clk), .rst_n_i(rst_n), .interface_select_i(sel),
    .os_select_i(os), .busy_i(busy), .conv_data_i(conv), .diag_flags_i(diag),
    .pins_i(hp), .pins_o(dev), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(32'h0), .wb_dat_o(rdat), .wb_ack_o(ack));
  aphp_host host (.clk_i(clk), .dev_i(dev), .pins_o(hp));
  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  function automatic logic [15:0] crc_next(input logic [15:0] c, input logic [15:0] d);
    for (int b = 15; b >= 0; b--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[b]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction
  task automatic cnv(input logic [15:0] base);
    for (int i = 0; i < 8; i++)
      conv[16*i +: 16] <= base + 16'(i);
    busy <= 1'b1;
    repeat (4) @(posedge clk);
    busy <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic rd_exp(input logic [15:0] e, input int h);
    host.rd(h, v);
    `CHK("word", e, v[15:0])
    crc = crc_next(crc, e);
  endtask
  task automatic wb(input logic wr, input logic [7:0] a);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    do @(posedge clk); while (ack !== 1'b1);
    w = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  initial begin
    for (int i = 0; i < 8; i++)
      diag[5*i +: 5] = {4'(i), 1'b0};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    cnv(16'hA000);
    for (int i = 0; i < 8; i++) begin
      rd_exp(16'hA000 + 16'(i), 3);
      `CHK("first", i == 0, v[16])
    end
    cnv(16'hB000);
    rd_exp(16'hB000, 3);
    rd_exp(16'hB001, 3);
    busy <= 1'b1;
    rd_exp(16'hB002, 3);
    cnv(16'hB100);
    rd_exp(16'hB100, 8);
    host.wr({1'b1, ADDR_CONFIG, 8'h00});
    rd_exp({1'b0, ADDR_CONFIG, CONFIG_RST}, 3);
    host.wr({1'b0, ADDR_CONFIG, 8'h40});
    host.wr({1'b0, ADDR_DIAG_CFG, 8'h04});
    host.wr(16'h0000);
    cnv(16'hC000);
    crc = CRC_SEED;
    for (int i = 0; i < 8; i++) begin
      rd_exp(16'hC000 + 16'(i), 3);
      rd_exp({1'b0, 4'(i), 3'(i), 8'h00}, 3);
    end
    rd_exp(crc, 3);
    os <= 3'b000;
    host.wr({1'b1, ADDR_CONFIG, 8'h00});
    cnv(16'hD000);
    sel <= 1'b1;
    host.rd(3, v);
    sel <= 1'b0;
    rd_exp(16'hD000, 3);
    host.hold_sel(1'b0);
    host.rd_strobe(3, v);
    `CHK("held select word", 16'hD001, v[15:0])
    host.rd_strobe(3, v);
    `CHK("held select next", 16'hD002, v[15:0])
    `CHK("held select first", 1'b0, v[16])
    host.hold_sel(1'b1);
    wb(1'b1, WB_CTRL_OFS);
    wb(1'b0, WB_CH_OFS);
    `CHK("wb result", {16'h0000, 16'hD000}, w)
    wb(1'b0, 8'hFC);
    `CHK("wb unmapped", 32'h0000_0000, w)
    give_verdict();
  end
endmodule
bind aphp_port aphp_port_sva chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .interface_select_i(interface_select_i), .pins_i(pins_i), .pins_o(pins_o),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));
